/* File: core/lsrc_cmd_decode.sv */
`default_nettype none

// --------------------------------------------------------------------
// Command byte decoder and register pointer
// --------------------------------------------------------------------
module lsrc_cmd_decode (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Byte stream from the serial front end
  input wire logic i_xfer_start,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_req,
  // Decoded outputs
  output logic [4:0] o_ptr,
  output logic o_data_wr,
  output logic o_irq_clear
);

  logic [4:0] ptr_q;
  logic [4:0] ptr_d;
  lsrc_pkg::lsrc_xfer_t type_q;
  lsrc_pkg::lsrc_xfer_t type_d;
  logic first_q;
  logic first_d;

  // Only the first byte of a write transfer may be a command
  wire first_byte = first_q | i_xfer_start;
  wire is_cmd = i_wr_valid & first_byte & i_wr_byte[lsrc_pkg::CMD_FLAG_BIT];
  wire [1:0] cmd_type = i_wr_byte[lsrc_pkg::CMD_TYPE_HI:lsrc_pkg::CMD_TYPE_LO];
  wire [4:0] cmd_addr = i_wr_byte[lsrc_pkg::CMD_ADDR_HI:lsrc_pkg::CMD_ADDR_LO];
  wire is_special = is_cmd & (cmd_type == lsrc_pkg::LSRC_XFER_SPECIAL);
  wire is_addr_cmd = is_cmd & ~is_special;
  wire data_acc = (i_wr_valid & ~is_cmd) | i_rd_req;
  wire auto_step = data_acc & (type_q == lsrc_pkg::LSRC_XFER_AUTO);

  // Special functions keep the pointer: they carry no register address
  assign o_irq_clear = is_special & (cmd_addr == lsrc_pkg::SF_LIGHT_CLEAR);
  assign o_data_wr = i_wr_valid & ~is_cmd;
  assign o_ptr = ptr_q;

  // Pointer wraps in its 5-bit field; repeated mode holds it
  assign ptr_d = is_addr_cmd ? cmd_addr :
                 auto_step ? ptr_q + 5'h01 : ptr_q;
  assign type_d = is_addr_cmd ? lsrc_pkg::lsrc_xfer_t'(cmd_type) : type_q;
  assign first_d = i_wr_valid ? 1'b0 : (i_xfer_start | first_q);

  // Pointer, type and first-byte flag
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_q <= lsrc_pkg::CMD_RESET[lsrc_pkg::CMD_ADDR_HI:lsrc_pkg::CMD_ADDR_LO];
      type_q <= lsrc_pkg::LSRC_XFER_REPEAT;
      first_q <= 1'b0;
    end else begin
      ptr_q <= ptr_d;
      type_q <= type_d;
      first_q <= first_d;
    end
  end

endmodule : lsrc_cmd_decode

`default_nettype wire

/* File: core/lsrc_irq_latch.sv */
`default_nettype none

// --------------------------------------------------------------------
// Sticky light interrupt flag
// --------------------------------------------------------------------
module lsrc_irq_latch (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Set and clear
  input wire logic i_set,
  input wire logic i_clear,
  // Flag
  output logic o_pending
);

  logic pending_q;
  logic pending_d;

  // Set beats clear so an event in the clearing cycle survives
  assign pending_d = i_set | (pending_q & ~i_clear);

  // Flag storage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
    end
  end

  assign o_pending = pending_q;

endmodule : lsrc_irq_latch

`default_nettype wire

/* File: core/lsrc_pkg.sv */
`default_nettype none

package lsrc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_FLAG_BIT = 7;
  localparam int CMD_TYPE_HI = 6;
  localparam int CMD_TYPE_LO = 5;
  localparam int CMD_ADDR_HI = 4;
  localparam int CMD_ADDR_LO = 0;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Transfer type carried in the command byte
  typedef enum logic [1:0] {
    LSRC_XFER_REPEAT  = 2'b00,
    LSRC_XFER_AUTO    = 2'b01,
    LSRC_XFER_RESV    = 2'b10,
    LSRC_XFER_SPECIAL = 2'b11
  } lsrc_xfer_t;

  // Special function codes in the address field
  localparam logic [4:0] SF_NONE = 5'h00;
  localparam logic [4:0] SF_LIGHT_CLEAR = 5'h06;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_FUNCTION_ENABLE = 5'h00;
  localparam logic [4:0] ADDR_INTEGRATION_TIME = 5'h01;
  localparam logic [4:0] ADDR_WAIT_TIME = 5'h03;
  localparam logic [4:0] ADDR_LOW_THRESHOLD_LO = 5'h04;
  localparam logic [4:0] ADDR_LOW_THRESHOLD_HI = 5'h05;
  localparam logic [4:0] ADDR_HIGH_THRESHOLD_LO = 5'h06;
  localparam logic [4:0] ADDR_HIGH_THRESHOLD_HI = 5'h07;
  localparam logic [4:0] ADDR_INTERRUPT_FILTER = 5'h0c;
  localparam logic [4:0] ADDR_DEVICE_CONFIGURATION = 5'h0d;
  localparam logic [4:0] ADDR_GAIN_CONTROL = 5'h0f;
  localparam logic [4:0] ADDR_PART_IDENTIFIER = 5'h12;
  localparam logic [4:0] ADDR_DEVICE_STATE = 5'h13;
  localparam logic [4:0] ADDR_VISIBLE_COUNT_LO = 5'h14;
  localparam logic [4:0] ADDR_VISIBLE_COUNT_HI = 5'h15;
  localparam logic [4:0] ADDR_INFRARED_COUNT_LO = 5'h16;
  localparam logic [4:0] ADDR_INFRARED_COUNT_HI = 5'h17;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_FUNCTION_ENABLE = 8'h00;
  localparam logic [7:0] RST_INTEGRATION_TIME = 8'hff;
  localparam logic [7:0] RST_WAIT_TIME = 8'hff;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_FILTER = 8'h00;
  localparam logic [7:0] RST_DEVICE_CONFIGURATION = 8'h00;
  localparam logic [7:0] RST_GAIN_CONTROL = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Read/write register table, one entry per storage byte
  // ----------------------------------------------------------------
  localparam int RW_COUNT = 10;
  localparam int IDX_ENABLE = 0;
  localparam int IDX_ITIME = 1;
  localparam int IDX_WAIT_TIME = 2;
  localparam int IDX_LTL = 3;
  localparam int IDX_LTH = 4;
  localparam int IDX_HTL = 5;
  localparam int IDX_HTH = 6;
  localparam int IDX_FILTER = 7;
  localparam int IDX_CONFIG = 8;
  localparam int IDX_GAIN = 9;

  localparam logic [4:0] RW_ADDR [RW_COUNT] = '{
    ADDR_FUNCTION_ENABLE, ADDR_INTEGRATION_TIME, ADDR_WAIT_TIME,
    ADDR_LOW_THRESHOLD_LO, ADDR_LOW_THRESHOLD_HI, ADDR_HIGH_THRESHOLD_LO,
    ADDR_HIGH_THRESHOLD_HI, ADDR_INTERRUPT_FILTER, ADDR_DEVICE_CONFIGURATION,
    ADDR_GAIN_CONTROL
  };
  localparam logic [7:0] RW_RESET [RW_COUNT] = '{
    RST_FUNCTION_ENABLE, RST_INTEGRATION_TIME, RST_WAIT_TIME,
    RST_THRESHOLD, RST_THRESHOLD, RST_THRESHOLD, RST_THRESHOLD,
    RST_INTERRUPT_FILTER, RST_DEVICE_CONFIGURATION, RST_GAIN_CONTROL
  };

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_IRQ_EN_BIT = 4;
  localparam int STATE_PENDING_BIT = 4;

endpackage : lsrc_pkg

`default_nettype wire

/* File: core/lsrc_regbank.sv */
// Operation
// - Registers reached only through serial byte port
// - Command address field sets register pointer
// - Bits six-five choose transfer type
// - Repeated type keeps pointer unchanged
// - Auto type steps pointer per byte
// - Special code six clears light interrupt
// - Interrupt clear acts once, self clearing
// - Low threshold from bytes four, five
// - High threshold from bytes six, seven
// - Visible count readable at 0x14/0x15
// - Infrared count readable at 0x16/0x17
// - Enable register read/write, resets zero
// - Reads use pointer from previous command
// - Non-command bytes stored at kept pointer
// - Interrupt holds until clear command
`default_nettype none

module lsrc_regbank #(
  parameter logic [7:0] PART_ID = 8'h5a // Arbitrary identity value
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Byte port from the serial front end
  input wire logic i_xfer_start,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_req,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Conversion engine results
  input wire logic i_count_load,
  input wire logic [15:0] i_visible_count,
  input wire logic [15:0] i_infrared_count,
  input wire logic [7:0] i_status,
  input wire logic i_light_event,
  // Settings towards the engine
  output logic [7:0] o_function_enable,
  output logic [7:0] o_integration_time,
  output logic [7:0] o_wait_time,
  output logic [15:0] o_low_threshold,
  output logic [15:0] o_high_threshold,
  output logic [7:0] o_interrupt_filter,
  output logic [7:0] o_device_configuration,
  output logic [7:0] o_gain_control,
  // Interrupt
  output logic o_irq_pending,
  output logic o_irq_n
);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (lsrc_pkg::RW_COUNT < 1) begin : g_chk
    $error("lsrc_regbank needs at least one writable register");
  end

  // ------------------------------------------------------------------
  // Command decoding
  // ------------------------------------------------------------------
  logic [4:0] ptr;
  logic data_wr;
  logic irq_clear;

  // The pointer is the only path to any register; all access is bytes
  lsrc_cmd_decode u_cmd (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_xfer_start(i_xfer_start),
    .i_wr_valid(i_wr_valid),
    .i_wr_byte(i_wr_byte),
    .i_rd_req(i_rd_req),
    .o_ptr(ptr),
    .o_data_wr(data_wr),
    .o_irq_clear(irq_clear)
  );

  // ------------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------------
  logic [7:0] rw_q [lsrc_pkg::RW_COUNT];
  logic [lsrc_pkg::RW_COUNT-1:0] rw_hit;

  // One byte of storage per table entry, reset to its table value
  for (genvar g = 0; g < lsrc_pkg::RW_COUNT; g++) begin : g_rw
    assign rw_hit[g] = (ptr == lsrc_pkg::RW_ADDR[g]);
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        rw_q[g] <= lsrc_pkg::RW_RESET[g];
      end else if (data_wr && rw_hit[g]) begin
        rw_q[g] <= i_wr_byte;
      end
    end
  end

  // ------------------------------------------------------------------
  // Channel count snapshot
  // ------------------------------------------------------------------
  logic [15:0] visible_q;
  logic [15:0] infrared_q;

  // Both channels load together so a pair never mixes two conversions
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      visible_q <= lsrc_pkg::RST_COUNT;
      infrared_q <= lsrc_pkg::RST_COUNT;
    end else if (i_count_load) begin
      visible_q <= i_visible_count;
      infrared_q <= i_infrared_count;
    end
  end

  // ------------------------------------------------------------------
  // Light interrupt
  // ------------------------------------------------------------------
  logic pending;

  lsrc_irq_latch u_irq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(i_light_event),
    .i_clear(irq_clear),
    .o_pending(pending)
  );

  assign o_irq_pending = pending;

  // Status shows live engine bits with the pending flag overlaid
  logic [7:0] state_byte;
  always_comb begin
    state_byte = i_status;
    state_byte[lsrc_pkg::STATE_PENDING_BIT] = pending;
  end

  // Pin is gated by the enable mask; the flag itself always records
  logic irq_n_q;
  wire irq_n_d = ~(pending & rw_q[lsrc_pkg::IDX_ENABLE][lsrc_pkg::ENABLE_IRQ_EN_BIT]);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= irq_n_d;
    end
  end

  assign o_irq_n = irq_n_q;

  // ------------------------------------------------------------------
  // Read selection
  // ------------------------------------------------------------------
  logic [7:0] rw_rd;

  // At most one table entry matches, so an OR of gated bytes suffices
  always_comb begin
    rw_rd = lsrc_pkg::RD_UNMAPPED;
    for (int k = 0; k < lsrc_pkg::RW_COUNT; k++) begin
      rw_rd = rw_rd | (rw_hit[k] ? rw_q[k] : 8'h00);
    end
  end

  // Read-only and unmapped decode; unmapped answers zero
  wire [7:0] rd_data_d =
    (|rw_hit) ? rw_rd :
    (ptr == lsrc_pkg::ADDR_PART_IDENTIFIER) ? PART_ID :
    (ptr == lsrc_pkg::ADDR_DEVICE_STATE) ? state_byte :
    (ptr == lsrc_pkg::ADDR_VISIBLE_COUNT_LO) ? visible_q[7:0] :
    (ptr == lsrc_pkg::ADDR_VISIBLE_COUNT_HI) ? visible_q[15:8] :
    (ptr == lsrc_pkg::ADDR_INFRARED_COUNT_LO) ? infrared_q[7:0] :
    (ptr == lsrc_pkg::ADDR_INFRARED_COUNT_HI) ? infrared_q[15:8] :
    lsrc_pkg::RD_UNMAPPED;

  logic [7:0] rd_data_q;
  logic rd_valid_q;

  // Read answer one cycle after the request, at the held pointer
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_rd_req;
      if (i_rd_req) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;

  // ------------------------------------------------------------------
  // Settings outputs
  // ------------------------------------------------------------------
  // Thresholds pair their bytes; a half-written pair is seen at once
  assign o_function_enable = rw_q[lsrc_pkg::IDX_ENABLE];
  assign o_integration_time = rw_q[lsrc_pkg::IDX_ITIME];
  assign o_wait_time = rw_q[lsrc_pkg::IDX_WAIT_TIME];
  assign o_low_threshold = {rw_q[lsrc_pkg::IDX_LTH], rw_q[lsrc_pkg::IDX_LTL]};
  assign o_high_threshold = {rw_q[lsrc_pkg::IDX_HTH], rw_q[lsrc_pkg::IDX_HTL]};
  assign o_interrupt_filter = rw_q[lsrc_pkg::IDX_FILTER];
  assign o_device_configuration = rw_q[lsrc_pkg::IDX_CONFIG];
  assign o_gain_control = rw_q[lsrc_pkg::IDX_GAIN];

endmodule : lsrc_regbank

`default_nettype wire

/* File: testbench/lsrc_host.sv */
`default_nettype none

// ----------------------------------------------------------------
// Serial host model on the byte port
// ----------------------------------------------------------------
module lsrc_host (
  // Clock
  input wire logic i_clk,
  // Byte port towards the device
  output logic o_xfer_start,
  output logic o_wr_valid,
  output logic [7:0] o_wr_byte,
  output logic o_rd_req,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet port at time zero
  initial begin
    o_xfer_start = 1'b0;
    o_wr_valid = 1'b0;
    o_wr_byte = 8'h00;
    o_rd_req = 1'b0;
  end

  // One byte per cycle, held until the next call changes it
  task put(input logic st, input logic [7:0] b);
    @(negedge i_clk);
    o_xfer_start = st;
    o_wr_valid = 1'b1;
    o_wr_byte = b;
  endtask : put

  // Command opens a transfer: flag bit set, reserved type never sent
  task cmd(input logic [1:0] t, input logic [4:0] a);
    put(1'b1, {1'b1, t, a});
  endtask : cmd

  // Released data shows the inverse, so a stale byte cannot pass
  task idle;
    @(negedge i_clk);
    o_xfer_start = 1'b0;
    o_wr_valid = 1'b0;
    o_wr_byte = ~o_wr_byte;
  endtask : idle

  // Answer is taken in the cycle after the request
  task rd(input logic st, output logic [7:0] d);
    @(negedge i_clk);
    o_xfer_start = st;
    o_wr_valid = 1'b0;
    o_rd_req = 1'b1;
    @(negedge i_clk);
    o_xfer_start = 1'b0;
    o_rd_req = 1'b0;
    d = i_rd_valid ? i_rd_data : 8'hxx;
  endtask : rd
endmodule : lsrc_host

`default_nettype wire

/* File: testbench/lsrc_regbank_props.sv */
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the register bank
// ----------------------------------------------------------------
module lsrc_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Byte port
  input wire logic i_xfer_start,
  input wire logic i_wr_valid,
  input wire logic [7:0] i_wr_byte,
  input wire logic i_rd_req,
  input wire logic o_rd_valid,
  // Settings and interrupt
  input wire logic i_light_event,
  input wire logic [7:0] o_function_enable,
  input wire logic [15:0] o_low_threshold,
  input wire logic [15:0] o_high_threshold,
  input wire logic o_irq_pending,
  input wire logic o_irq_n
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Only the opening byte of a transfer can be a command
  wire logic first_wr = i_xfer_start && i_wr_valid;
  wire logic irq_en = o_function_enable[4];

  property p_rd_answer;
    i_rd_req |=> o_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");

  property p_irq_set;
    i_light_event |=> o_irq_pending;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("event did not set flag");

  property p_irq_hold;
    o_irq_pending && !(i_wr_valid && i_wr_byte == 8'he6) |=> o_irq_pending;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("flag dropped alone");

  property p_irq_cause;
    $rose(o_irq_pending) |-> $past(i_light_event);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("flag rose unasked");

  property p_irq_clear;
    first_wr && i_wr_byte == 8'he6 && !i_light_event |=> !o_irq_pending;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("clear code ignored");

  property p_noop;
    first_wr && i_wr_byte == 8'he0 && !i_light_event |=> $stable(o_irq_pending);
  endproperty
  a_noop: assert property (p_noop) else $error("no-op code acted");

  // Pin follows flag and mask one cycle later
  property p_irq_out;
    1'b1 |-> o_irq_n == !($past(o_irq_pending) && $past(irq_en));
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("irq pin wrong");

  property p_keep;
    !i_wr_valid |=> $stable(o_low_threshold) && $stable(o_high_threshold)
      && $stable(o_function_enable);
  endproperty
  a_keep: assert property (p_keep) else $error("register moved without write");

  property p_wr_low;
    first_wr && i_wr_byte[7] && i_wr_byte[6:5] != 2'b11 && i_wr_byte[4:0] == 5'h04
      ##1 i_wr_valid && !i_xfer_start |=> o_low_threshold[7:0] == $past(i_wr_byte);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low byte not stored");

endmodule : lsrc_props

bind lsrc_regbank lsrc_props u_props (.i_clk(i_clk), .i_rst(i_rst),
  .i_xfer_start(i_xfer_start), .i_wr_valid(i_wr_valid), .i_wr_byte(i_wr_byte),
  .i_rd_req(i_rd_req), .o_rd_valid(o_rd_valid), .i_light_event(i_light_event),
  .o_function_enable(o_function_enable), .o_low_threshold(o_low_threshold),
  .o_high_threshold(o_high_threshold), .o_irq_pending(o_irq_pending), .o_irq_n(o_irq_n));

`default_nettype wire

/* File: testbench/lsrc_regbank_test.sv */
`default_nettype none

module lsrc_regbank_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ID = 8'h3c; // Arbitrary identity value

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_count_load = 1'b0;
  logic [15:0] i_visible_count = 16'h0000;
  logic [15:0] i_infrared_count = 16'h0000;
  logic [7:0] i_status = 8'h00;
  logic i_light_event = 1'b0;
  wire logic xs, wv, rq, rv, pend, irq_n;
  wire logic [7:0] wb, rdd, en, cfg, itm, wtm, flt, gn;
  wire logic [15:0] lth, hth;
  logic [7:0] mir [32];
  logic [7:0] d;
  int fail_count = 0;
  int n_checks = 0;

  lsrc_host host (.i_clk(i_clk), .o_xfer_start(xs), .o_wr_valid(wv), .o_wr_byte(wb),
    .o_rd_req(rq), .i_rd_data(rdd), .i_rd_valid(rv));

  lsrc_regbank #(.PART_ID(ID)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_xfer_start(xs),
    .i_wr_valid(wv), .i_wr_byte(wb), .i_rd_req(rq), .o_rd_data(rdd), .o_rd_valid(rv),
    .i_count_load(i_count_load), .i_visible_count(i_visible_count),
    .i_infrared_count(i_infrared_count), .i_status(i_status),
    .i_light_event(i_light_event), .o_function_enable(en), .o_integration_time(itm),
    .o_wait_time(wtm), .o_low_threshold(lth), .o_high_threshold(hth),
    .o_interrupt_filter(flt), .o_device_configuration(cfg), .o_gain_control(gn),
    .o_irq_pending(pend), .o_irq_n(irq_n));

  // 200 MHz clock
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // Whole map read with auto-increment, one lap plus the wrap
  task check_all;
    host.cmd(2'b01, 5'h00);
    for (int i = 0; i < 33; i++) begin
      host.rd(1'b0, d);
      chk("reg", 16'(mir[i % 32]), 16'(d));
    end
  endtask : check_all

  // Cut a hang well past the expected run of about two hundred cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    final_report();
  end

  initial begin
    for (int i = 0; i < 32; i++) begin
      mir[i] = 8'h00;
    end
    mir[1] = 8'hff;
    mir[3] = 8'hff;
    mir[18] = ID;
    repeat (10) @(posedge i_clk);
    @(negedge i_clk) i_rst = 1'b0;
    check_all();
    // Auto-increment across both thresholds
    host.cmd(2'b01, 5'h04);
    for (int k = 0; k < 4; k++) begin
      host.put(1'b0, 8'h11 * 8'(k + 1));
      mir[k + 4] = 8'h11 * 8'(k + 1);
    end
    host.idle();
    chk("low_thr", 16'h2211, lth);
    chk("high_thr", 16'h4433, hth);
    // Repeated type keeps the pointer; a later flagged byte is data
    host.cmd(2'b00, 5'h00);
    host.put(1'b0, 8'h12);
    host.put(1'b0, 8'h93);
    host.idle();
    chk("enable", 16'h0093, 16'(en));
    host.put(1'b1, 8'h15);
    host.idle();
    chk("enable", 16'h0015, 16'(en));
    mir[0] = 8'h15;
    host.cmd(2'b00, 5'h0d);
    host.put(1'b0, 8'h9b);
    host.idle();
    chk("config", 16'h009b, 16'(cfg));
    mir[13] = 8'h9b;
    // Timing, filter and gain bytes; bytes sent to the unmapped holes between them are dropped
    host.cmd(2'b01, 5'h01);
    host.put(1'b0, 8'h3c);
    host.put(1'b0, 8'hee);
    host.put(1'b0, 8'h5a);
    host.cmd(2'b01, 5'h0e);
    host.put(1'b0, 8'h66);
    host.put(1'b0, 8'h02);
    host.cmd(2'b00, 5'h0c);
    host.put(1'b0, 8'h07);
    host.idle();
    chk("itime", 16'h003c, 16'(itm));
    chk("wait_time", 16'h005a, 16'(wtm));
    chk("filter", 16'h0007, 16'(flt));
    chk("gain", 16'h0002, 16'(gn));
    mir[1] = 8'h3c;
    mir[3] = 8'h5a;
    mir[12] = 8'h07;
    mir[15] = 8'h02;
    // Read-only and unmapped writes are dropped
    host.cmd(2'b01, 5'h12);
    for (int k = 0; k < 6; k++) begin
      host.put(1'b0, 8'hff);
    end
    host.cmd(2'b00, 5'h02);
    host.put(1'b0, 8'h77);
    host.idle();
    // Fresh counts and status
    @(negedge i_clk);
    i_visible_count = 16'h8a5c;
    i_infrared_count = 16'h1b37;
    i_status = 8'h21;
    i_count_load = 1'b1;
    @(negedge i_clk) i_count_load = 1'b0;
    mir[19] = 8'h21;
    mir[20] = 8'h5c;
    mir[21] = 8'h8a;
    mir[22] = 8'h37;
    mir[23] = 8'h1b;
    check_all();
    // Interrupt raised, no-op code, then cleared
    host.cmd(2'b00, 5'h13);
    host.idle();
    @(negedge i_clk) i_light_event = 1'b1;
    @(negedge i_clk) i_light_event = 1'b0;
    chk("pending", 16'h0001, 16'(pend));
    @(negedge i_clk);
    chk("irq_n", 16'h0000, 16'(irq_n));
    host.cmd(2'b11, 5'h00);
    host.idle();
    chk("pending", 16'h0001, 16'(pend));
    host.rd(1'b1, d);
    chk("status", 16'h0031, 16'(d));
    host.cmd(2'b11, 5'h06);
    host.idle();
    chk("pending", 16'h0000, 16'(pend));
    host.idle();
    chk("irq_n", 16'h0001, 16'(irq_n));
    host.rd(1'b1, d);
    chk("status", 16'h0021, 16'(d));
    // Event in the very cycle of the clear: the set must win
    i_light_event = 1'b1;
    host.cmd(2'b11, 5'h06);
    host.idle();
    i_light_event = 1'b0;
    chk("pending", 16'h0001, 16'(pend));
    host.cmd(2'b11, 5'h06);
    host.idle();
    chk("pending", 16'h0000, 16'(pend));
    final_report();
  end
endmodule : lsrc_regbank_test

`default_nettype wire
